// File: hdl/tzc_edge.sv
// synchroniser and edge detector for the external count input
`timescale 1ns/1ps
module tzc_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pin level
    input wire logic din,
    // one-cycle edge pulses
    output logic rise,
    output logic fall
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic last_q, last_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
        last_d = sync_q;
        // only the settled stages feed the edge decision
        rise = sync_q & ~last_q;
        fall = ~sync_q & last_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end
endmodule

// File: hdl/tzc_pkg.sv
// constants, register map and helpers shared by the timer zero counter
package tzc_pkg;
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] IDX_OPTION = 8'h02;
    localparam logic [7:0] IDX_CTRL = 8'h03;
    localparam logic [7:0] IDX_ICTL = 8'h0B;
    // option register fields
    localparam int OPT_SRC_BIT = 5;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_RATIO_LSB = 0;
    localparam int OPT_RATIO_W = 3;
    // interrupt_control fields
    localparam int ICTL_EN_BIT = 5;
    localparam int ICTL_FLAG_BIT = 2;
    // control register fields
    localparam int CTRL_SLEEP_BIT = 0;
    // reset values and the count maximum
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int INSN_HZ = 12_500_000;
    localparam int INSN_DIV_DFLT = CLK_HZ / INSN_HZ;
    localparam logic [1:0] INHIBIT_CYC = 2'h2;

    typedef enum logic [2:0] {
        TZC_SEL_NONE, TZC_SEL_COUNT, TZC_SEL_OPTION, TZC_SEL_CTRL, TZC_SEL_ICTL
    } tzc_sel_e;

    function automatic tzc_sel_e tzc_decode(input logic [ADDR_W-1:0] addr);
        tzc_sel_e sel;
        sel = TZC_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[ADDR_W-1:2])
                IDX_COUNT[5:0]: sel = TZC_SEL_COUNT;
                IDX_OPTION[5:0]: sel = TZC_SEL_OPTION;
                IDX_CTRL[5:0]: sel = TZC_SEL_CTRL;
                IDX_ICTL[5:0]: sel = TZC_SEL_ICTL;
                default: sel = TZC_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // mask of prescaler bits that must be all ones for an output pulse;
    // the timer sees 1:2 at ratio 0, the watchdog 1:1
    function automatic logic [7:0] tzc_ps_mask(
        input logic [OPT_RATIO_W-1:0] ratio, input logic timer);
        logic [8:0] span;
        span = 9'h001 << ratio;
        if (timer) begin
            span = span << 1;
        end
        return 8'(span - 9'h001);
    endfunction
endpackage

// File: hdl/tzc_top.sv
// timer zero counter with shared prescaler behind an axi4-lite slave
//
// Notes on behaviour
// - source select clear, no prescaler: count steps every instruction cycle.
// - a count register write stops counting for two instruction cycles.
// - source select set: count advances on external count input edges.
// - edge polarity clear counts rising edges, set counts falling edges.
// - one 8-bit prescaler serves timer or watchdog, never both.
// - prescaler count cannot be read or written by software.
// - wrap from all ones to zero sets the overflow flag.
// - interrupt request only while overflow enable is set.
// - sleep stops the timer, so overflow cannot wake the processor.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tzc_top
    import tzc_pkg::*;
#(
    parameter int INSN_DIV = INSN_DIV_DFLT
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // write address, data and response channels
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // read address and data channels
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // external count input and watchdog timebase
    input wire logic EXT_COUNT_IN,
    input wire logic WDT_CLK_EN,
    output logic WDT_TICK,
    // interrupt
    output logic IRQ
);
    localparam int DIV_W = $clog2(INSN_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSN_DIV - 1);
    // divider, edge capture and timer core
    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d, pend_q, pend_d;
    logic ext_rise, ext_fall, ext_hit;
    logic [7:0] count_q, count_d, ps_q, ps_d, mask, opt_q, opt_d;
    logic [1:0] inh_q, inh_d;
    logic en_q, en_d, flag_q, flag_d, sleep_q, sleep_d;
    logic wdt_q, wdt_d, irq_q, irq_d;
    logic raw, adv, ovf, flag_clr;
    // write channel
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d, bvalid_q, bvalid_d, wr_fire;
    logic [1:0] bresp_q, bresp_d;
    tzc_sel_e wsel;
    // read channel
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    tzc_sel_e rsel;

    tzc_edge u_edge (.clk(MCLK), .rst(RST), .din(EXT_COUNT_IN),
        .rise(ext_rise), .fall(ext_fall));

    // an edge is held until the next instruction cycle takes it;
    // a new edge in the taking cycle is kept, not lost
    always_comb begin
        div_d = (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
        tick_d = (div_q == DIV_LAST);
        ext_hit = opt_q[OPT_EDGE_BIT] ? ext_fall : ext_rise;
        pend_d = ext_hit | (pend_q & ~tick_q);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            div_q <= '0;
            tick_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
            pend_q <= pend_d;
        end
    end

    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    assign wsel = tzc_decode(awaddr_q);
    assign rsel = tzc_decode(ARADDR);
    always_comb begin
        count_d = count_q;
        ps_d = ps_q;
        inh_d = inh_q;
        opt_d = opt_q;
        en_d = en_q;
        sleep_d = sleep_q;
        wdt_d = 1'b0;
        raw = 1'b0;
        adv = 1'b0;
        flag_clr = 1'b0;
        mask = tzc_ps_mask(opt_q[OPT_RATIO_LSB +: OPT_RATIO_W],
                           ~opt_q[OPT_PSA_BIT]);
        // sleep masks the instruction-cycle tick to the timer, but not the watchdog path
        if (tick_q && !sleep_q) begin
            if (inh_q != 2'h0) begin
                inh_d = inh_q - 2'h1;
            end else begin
                raw = opt_q[OPT_SRC_BIT] ? pend_q : 1'b1;
            end
        end
        if (opt_q[OPT_PSA_BIT]) begin
            adv = raw;
            if (WDT_CLK_EN) begin
                ps_d = ps_q + 8'h01;
                wdt_d = (ps_q & mask) == mask;
            end
        end else if (raw) begin
            ps_d = ps_q + 8'h01;
            adv = (ps_q & mask) == mask;
        end
        if (adv) begin
            count_d = count_q + 8'h01;
        end
        ovf = adv && (count_q == CNT_MAX);
        if (wr_fire && wlane_q) begin
            unique case (wsel)
                TZC_SEL_COUNT: begin
                    count_d = wbyte_q;
                    inh_d = INHIBIT_CYC;
                    if (!opt_q[OPT_PSA_BIT]) begin
                        ps_d = '0;
                    end
                end
                TZC_SEL_OPTION: begin
                    opt_d = wbyte_q;
                    // a change of owner restarts the prescaler
                    if (wbyte_q[OPT_PSA_BIT] != opt_q[OPT_PSA_BIT]) begin
                        ps_d = '0;
                    end
                end
                TZC_SEL_CTRL: sleep_d = wbyte_q[CTRL_SLEEP_BIT];
                TZC_SEL_ICTL: begin
                    en_d = wbyte_q[ICTL_EN_BIT];
                    flag_clr = wbyte_q[ICTL_FLAG_BIT];
                end
                TZC_SEL_NONE: flag_clr = 1'b0;
            endcase
        end
        flag_d = ovf | (flag_q & ~flag_clr);
        irq_d = flag_d & en_d;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            count_q <= COUNT_RST;
            ps_q <= '0;
            inh_q <= 2'h0;
            opt_q <= OPT_RST;
            en_q <= 1'b0;
            flag_q <= 1'b0;
            sleep_q <= 1'b0;
            wdt_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            count_q <= count_d;
            ps_q <= ps_d;
            inh_q <= inh_d;
            opt_q <= opt_d;
            en_q <= en_d;
            flag_q <= flag_d;
            sleep_q <= sleep_d;
            wdt_q <= wdt_d;
            irq_q <= irq_d;
        end
    end

    // write side: address and data are taken in any order, one write at a time
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (AWVALID && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = AWADDR;
        end
        if (WVALID && wready_q) begin
            w_have_d = 1'b1;
            wbyte_d = WDATA[7:0];
            wlane_d = WSTRB[0];
        end
        if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wsel == TZC_SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
        awready_d = ~aw_have_d & ~bvalid_d;
        wready_d = ~w_have_d & ~bvalid_d;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // read side; the prescaler has no address of its own
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
        if (ARVALID && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = '0;
            unique case (rsel)
                TZC_SEL_COUNT: rdata_d[7:0] = count_q;
                TZC_SEL_OPTION: rdata_d[7:0] = opt_q;
                TZC_SEL_CTRL: rdata_d[CTRL_SLEEP_BIT] = sleep_q;
                TZC_SEL_ICTL: begin
                    rdata_d[ICTL_EN_BIT] = en_q;
                    rdata_d[ICTL_FLAG_BIT] = flag_q;
                end
                TZC_SEL_NONE: rresp_d = RESP_DECERR;
            endcase
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign WDT_TICK = wdt_q;
    assign IRQ = irq_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_timer_step: assert property (
        tick_q && !sleep_q && inh_q == 2'h0 && !opt_q[OPT_SRC_BIT]
        && opt_q[OPT_PSA_BIT] && !wr_fire
        |=> count_q == $past(count_q) + 8'h01)
        else $error("timer mode missed an instruction-cycle step");
    chk_write_inhibit: assert property (
        wr_fire && wlane_q && wsel == TZC_SEL_COUNT
        |=> inh_q == INHIBIT_CYC && count_q == $past(wbyte_q))
        else $error("count write did not load and arm the inhibit");
    chk_inhibit_hold: assert property (
        inh_q != 2'h0 && !wr_fire |=> $stable(count_q))
        else $error("count moved during the inhibit window");
    chk_counter_idle: assert property (
        opt_q[OPT_SRC_BIT] && !pend_q && !wr_fire |=> $stable(count_q))
        else $error("counter mode advanced without an edge");
    chk_edge_polarity: assert property (
        ext_rise && !opt_q[OPT_EDGE_BIT] && !RST |=> pend_q)
        else $error("selected rising edge was not captured");
    chk_ps_owner: assert property (
        WDT_TICK |-> $past(opt_q[OPT_PSA_BIT] && WDT_CLK_EN))
        else $error("watchdog tick without owning the prescaler");
    chk_overflow_flag: assert property (
        adv && count_q == CNT_MAX
        |=> flag_q && (count_q == '0 || $past(wr_fire)))
        else $error("wrap to zero did not set the overflow flag");
    chk_irq_masked: assert property (
        IRQ |-> $past(flag_d && en_d))
        else $error("interrupt raised while masked or flag clear");
    chk_sleep_freeze: assert property (
        sleep_q && !wr_fire ##1 sleep_q && !wr_fire |=> $stable(count_q))
        else $error("count moved during sleep");
    chk_ps_ratio: assert property (
        raw && !opt_q[OPT_PSA_BIT] && (ps_q & mask) != mask |-> !adv)
        else $error("timer advanced before the prescaler ratio elapsed");
    chk_sync_step: assert property (
        $changed(count_q) |-> $past(tick_q || wr_fire))
        else $error("count changed off an instruction-cycle edge");
    cov_overflow: cover property (adv && count_q == CNT_MAX);
    cov_ext_count: cover property (opt_q[OPT_SRC_BIT] && adv);
    cov_irq: cover property ($rose(IRQ));
    cov_wdt_tick: cover property (WDT_TICK);
endmodule

// File: testbench/testbench.sv
// register-level tests of the timer zero counter
`timescale 1ns/1ps
module testbench;
    import tzc_pkg::*;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] AWADDR = 8'h00;
    logic AWVALID = 1'b0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hF;
    logic WVALID = 1'b0;
    logic BREADY = 1'b0;
    logic [7:0] ARADDR = 8'h00;
    logic ARVALID = 1'b0;
    logic RREADY = 1'b0;
    logic WDT_CLK_EN = 1'b0;
    logic start = 1'b0;
    logic [7:0] toggles = 8'h00;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WDT_TICK, IRQ, pin, busy;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int wb, re, rs, tick_n;

    tzc_top #(.INSN_DIV(4)) uut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .EXT_COUNT_IN(pin), .WDT_CLK_EN(WDT_CLK_EN),
        .WDT_TICK(WDT_TICK), .IRQ(IRQ));
    tzc_pulse_src src (.clk(MCLK), .rst(RST), .start(start),
        .toggles(toggles), .half(8'h09), .pin(pin), .busy(busy));

    always #10 MCLK = ~MCLK;
    always @(posedge MCLK) cyc <= cyc + 1;
    always @(posedge MCLK) if (WDT_TICK === 1'b1) tick_n++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
        checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] er);
        int n = 0;
        @(posedge MCLK);
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= {24'h0, d};
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (BVALID !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            n++;
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
        end
        wb = cyc - 1;
        if (n >= 200) miscompares++;
        chk({30'h0, BRESP}, {30'h0, er});
        BREADY <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n = 0;
        @(posedge MCLK);
        rs = cyc;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (RVALID !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            n++;
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
        end
        re = cyc - 1;
        if (n >= 200) miscompares++;
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk({30'h0, r}, {30'h0, er});
        if (er == RESP_OKAY) chk(d, exp);
    endtask

    // two reads a whole number of periods apart see exactly that many steps
    task automatic rate(input logic [7:0] opt, input int p);
        logic [31:0] d1, d2;
        logic [1:0] r;
        int s1;
        axi_wr(8'h08, opt, RESP_OKAY);
        repeat (2 * p) @(posedge MCLK);
        axi_rd(8'h04, d1, r);
        s1 = rs;
        repeat (128) @(posedge MCLK);
        while ((cyc + 1 - s1) % p != 0) @(posedge MCLK);
        axi_rd(8'h04, d2, r);
        chk({24'h0, d2[7:0] - d1[7:0]}, 32'((rs - s1) / p));
    endtask

    task automatic pulse(input logic [7:0] n);
        int k = 0;
        start <= 1'b1;
        toggles <= n;
        @(posedge MCLK);
        start <= 1'b0;
        @(posedge MCLK);
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge MCLK);
            k++;
        end
        repeat (16) @(posedge MCLK);
    endtask

    task automatic final_report();
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int k;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        rdchk(8'h08, 32'h0, RESP_OKAY);
        rdchk(8'h0C, 32'h0, RESP_OKAY);
        rdchk(8'h2C, 32'h0, RESP_OKAY);
        rdchk(8'h10, 32'h0, RESP_DECERR);
        rdchk(8'h05, 32'h0, RESP_DECERR);
        axi_wr(8'h10, 8'hFF, RESP_DECERR);
        // a write with its low strobe clear must leave the register alone
        WSTRB <= 4'h0;
        axi_wr(8'h0C, 8'h01, RESP_OKAY);
        WSTRB <= 4'hF;
        rdchk(8'h0C, 32'h0, RESP_OKAY);
        axi_wr(8'h0C, 8'h01, RESP_OKAY);
        axi_wr(8'h04, 8'h5A, RESP_OKAY);
        repeat (40) @(posedge MCLK);
        rdchk(8'h04, 32'h5A, RESP_OKAY);
        axi_wr(8'h0C, 8'h00, RESP_OKAY);
        rate(8'h08, 4);
        rate(8'h00, 8);
        rate(8'h01, 16);
        rate(8'h02, 32);
        axi_wr(8'h08, 8'h08, RESP_OKAY);
        axi_wr(8'h04, 8'h40, RESP_OKAY);
        k = wb;
        repeat (40) @(posedge MCLK);
        axi_rd(8'h04, d, r);
        chk_in(d - 32'h40, (re - k - 1) / 4 - 2, (re - k + 2) / 4 - 2);
        // masked overflow still sets the flag
        axi_wr(8'h2C, 8'h04, RESP_OKAY);
        axi_wr(8'h04, 8'hFE, RESP_OKAY);
        repeat (40) @(posedge MCLK);
        chk({31'h0, IRQ}, 32'h0);
        rdchk(8'h2C, 32'h04, RESP_OKAY);
        axi_wr(8'h2C, 8'h20, RESP_OKAY);
        chk({31'h0, IRQ}, 32'h1);
        axi_wr(8'h2C, 8'h24, RESP_OKAY);
        chk({31'h0, IRQ}, 32'h0);
        rdchk(8'h2C, 32'h20, RESP_OKAY);
        axi_wr(8'h04, 8'hFE, RESP_OKAY);
        k = 0;
        while (IRQ !== 1'b1 && k < 40) begin
            @(posedge MCLK);
            k++;
        end
        chk({31'h0, IRQ}, 32'h1);
        axi_wr(8'h2C, 8'h04, RESP_OKAY);
        // pin idles low: five toggles give three rising edges
        axi_wr(8'h08, 8'h28, RESP_OKAY);
        axi_wr(8'h04, 8'h00, RESP_OKAY);
        pulse(8'h05);
        rdchk(8'h04, 32'h03, RESP_OKAY);
        axi_wr(8'h08, 8'h38, RESP_OKAY);
        axi_wr(8'h04, 8'h00, RESP_OKAY);
        pulse(8'h03);
        rdchk(8'h04, 32'h02, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'h08, 8'h08 | 8'(i), RESP_OKAY);
            tick_n = 0;
            repeat (16) begin
                @(posedge MCLK);
                WDT_CLK_EN <= 1'b1;
                @(posedge MCLK);
                WDT_CLK_EN <= 1'b0;
                repeat (2) @(posedge MCLK);
            end
            repeat (4) @(posedge MCLK);
            chk(32'(tick_n), 32'(16 >> i));
        end
        final_report();
    end

    initial begin
        repeat (30000) @(posedge MCLK);
        miscompares++;
        final_report();
    end
endmodule

// File: testbench/tzc_pulse_src.sv
// pulse source that toggles the external count pin on request
`timescale 1ns/1ps
module tzc_pulse_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic [7:0] toggles,
    input wire logic [7:0] half,
    // pin and status
    output logic pin,
    output logic busy
);
    logic [7:0] left_q;
    logic [7:0] tim_q;
    // each level is held half+1 clocks so the synchroniser never drops it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin <= 1'b0;
            busy <= 1'b0;
            left_q <= 8'h00;
            tim_q <= 8'h00;
        end else if (start && !busy) begin
            left_q <= toggles;
            tim_q <= half;
            busy <= 1'b1;
        end else if (busy) begin
            if (tim_q != 8'h00) begin
                tim_q <= tim_q - 8'h01;
            end else begin
                pin <= ~pin;
                left_q <= left_q - 8'h01;
                tim_q <= half;
                busy <= (left_q != 8'h01);
            end
        end
    end
endmodule
